// >>> verilog/irq_remap_defines.svh
// constants for the interrupt vector remap block
`ifndef IRQ_REMAP_DEFINES_SVH
`define IRQ_REMAP_DEFINES_SVH
`define ADDR_W 4
`define OFS_VECTOR_MAP_SELECT 4'h0
`define OFS_FACTOR_SELECT_LOW 4'h4
`define OFS_FACTOR_SELECT_HIGH 4'h8
`define OFS_NMI_PORT_CFG 4'hc
`define RST_VECTOR_MAP_SELECT 32'h0000_0000
`define RST_FACTOR_SELECT 32'h0000_0000
`define N_ROUTE 8
`define N_AGG 48
`define FIRST_MASKED_AGG 11
`define LAST_MASKED_AGG 47
`define FIRST_ROUTED_VEC 19
`define N_EXT 12
`define N_BT 8
`define N_SER 4
`define N_MOT 3
`define N_DMA 4
`define N_FACTOR 32
`define CODE_EXT0 8'h01
`define CODE_BT0 8'h0d
`define CODE_SER0 8'h15
`define CODE_MOT0 8'h19
`define CODE_DMA0 8'h1c
`define CODE_RESERVED 8'h20
`endif

// >>> verilog/irq_remap_pkg.sv
// types for the interrupt remap link; only the core end uses one of them (host_state_t)
`default_nettype none
package irq_remap_pkg;
    typedef logic [7:0] factor_code_t;
    typedef enum logic [1:0] {BUS_READ, BUS_WRITE} bus_op_t;
    typedef enum {HOST_IDLE, HOST_ISSUE, HOST_WAIT} host_state_t;
endpackage
`default_nettype wire

// >>> verilog/irq_remap_if.sv
// link between the remap device and its controlling core
`default_nettype none
`include "irq_remap_defines.svh"
interface irq_remap_if;
    logic req;
    logic wr;
    logic [`ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;
    logic [`N_AGG-1:0] agg_irq;
    logic [`N_ROUTE-1:0] routed_irq;
    logic [`N_AGG-1:0] monitor;
    logic alt_mode;
    logic nmi;
    modport device (input req, wr, addr, wdata,
                    output rdata, ack, agg_irq, routed_irq, monitor, alt_mode, nmi);
    modport core (output req, wr, addr, wdata,
                  input rdata, ack, agg_irq, routed_irq, monitor, alt_mode, nmi);
endinterface
`default_nettype wire

// >>> verilog/factor_decode.sv
// decodes one selection code into a one-hot factor mask
`default_nettype none
`include "irq_remap_defines.svh"
module factor_decode (
    input wire logic [7:0] i_code,
    output logic [`N_FACTOR-1:0] o_onehot
);
    // codes 0x00 and 0x20..0xff give an empty mask
    always_comb begin
        o_onehot = '0;
        if (i_code != 8'h00 && i_code < `CODE_RESERVED) begin
            o_onehot[i_code[4:0]] = 1'b1;
        end
    end
endmodule // factor_decode
`default_nettype wire

// >>> verilog/irq_remap_device.sv
// interrupt vector remap device end
// Overview of operation
// - map bit chooses legacy or alternate vectors
// - map select bits 31:1 read zero
// - low selector drives vectors 19-22, alternate only
// - low selector bytes map vectors 19..22
// - high selector drives vectors 23-26, alternate only
// - high selector bytes map vectors 23..26
// - routed factors masked from aggregates 11-47 and their monitors
// - software keeps selection codes unique
// - code 0x00 routes nothing; 0x20+ reserved
// - codes 0x01-0x0c route external channels 0-11
// - codes 0x0d-0x14 route base timers, both outputs
// - codes 0x15-0x18 route serial receive 0-3
// - 0x19-0x1b motor timers, 0x1c-0x1f dma
// - requests are levels, handler clears source
// - nmi pin masked until port configured
`default_nettype none
`include "irq_remap_defines.svh"
module irq_remap_device (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    irq_remap_if.device bus,
    input wire logic [`N_EXT-1:0] i_ext_irq,
    input wire logic [`N_BT-1:0] i_bt_irq0,
    input wire logic [`N_BT-1:0] i_bt_irq1,
    input wire logic [`N_SER-1:0] i_ser_rx_irq,
    input wire logic [`N_MOT-1:0] i_mot_zero_irq,
    input wire logic [`N_DMA-1:0] i_dma_irq,
    input wire logic [`N_AGG-1:0] i_legacy_agg,
    input wire logic [`N_AGG-1:0] i_alt_agg,
    input wire logic [`N_AGG*`N_FACTOR-1:0] i_agg_factor_map,
    input wire logic i_nonmaskable_pin_n,
    input wire logic i_watchdog_nmi
);
    // ************************************************************
    // registers
    // ************************************************************
    logic map_sel_ff;
    logic [31:0] sel_low_ff;
    logic [31:0] sel_high_ff;
    logic nmi_en_ff;
    logic [31:0] rdata_ff;
    logic ack_ff;
    logic [`N_AGG-1:0] agg_ff;
    logic [`N_AGG-1:0] mon_ff;
    logic [`N_ROUTE-1:0] routed_ff;
    logic nmi_ff;
    logic [2:0] nmi_sync_ff;
    logic nmi_level_ff;
    logic [`N_FACTOR-1:0] factors;
    logic [63:0] sel_all;
    logic [`N_FACTOR-1:0] onehot [`N_ROUTE];
    logic [`N_FACTOR-1:0] routed_set;
    logic [`N_ROUTE-1:0] nxt_routed;
    logic [`N_AGG-1:0] nxt_agg;
    logic [`N_AGG-1:0] raw_agg;

    // ************************************************************
    // register writes
    // ************************************************************
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            map_sel_ff <= 1'(`RST_VECTOR_MAP_SELECT);
            sel_low_ff <= `RST_FACTOR_SELECT;
            sel_high_ff <= `RST_FACTOR_SELECT;
            nmi_en_ff <= 1'b0;
        end else if (i_ce && bus.req && bus.wr) begin
            if (bus.addr == `OFS_VECTOR_MAP_SELECT) begin
                map_sel_ff <= bus.wdata[0];
            end else if (bus.addr == `OFS_FACTOR_SELECT_LOW) begin
                sel_low_ff <= bus.wdata;
            end else if (bus.addr == `OFS_FACTOR_SELECT_HIGH) begin
                sel_high_ff <= bus.wdata;
            end else if (bus.addr == `OFS_NMI_PORT_CFG) begin
                nmi_en_ff <= bus.wdata[0];
            end
        end
    end

    // ************************************************************
    // read path, one-cycle ack
    // ************************************************************
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_ff <= 32'h0000_0000;
            ack_ff <= 1'b0;
        end else if (i_ce) begin
            ack_ff <= bus.req;
            if (bus.req && !bus.wr) begin
                if (bus.addr == `OFS_VECTOR_MAP_SELECT) begin
                    rdata_ff <= {31'h0000_0000, map_sel_ff};
                end else if (bus.addr == `OFS_FACTOR_SELECT_LOW) begin
                    rdata_ff <= sel_low_ff;
                end else if (bus.addr == `OFS_FACTOR_SELECT_HIGH) begin
                    rdata_ff <= sel_high_ff;
                end else if (bus.addr == `OFS_NMI_PORT_CFG) begin
                    rdata_ff <= {31'h0000_0000, nmi_en_ff};
                end else begin
                    rdata_ff <= 32'h0000_0000;
                end
            end
        end
    end

    // ************************************************************
    // factor vector and routing
    // ************************************************************
    // bit index equals selection code
    assign factors = {i_dma_irq, i_mot_zero_irq, i_ser_rx_irq,
                      i_bt_irq0 | i_bt_irq1, i_ext_irq, 1'b0};
    assign sel_all = {sel_high_ff, sel_low_ff};

    genvar g;
    generate
        for (g = 0; g < `N_ROUTE; g = g + 1) begin : g_route
            factor_decode u_dec (
                .i_code(sel_all[g*8 +: 8]),
                .o_onehot(onehot[g])
            );
            assign nxt_routed[g] = map_sel_ff && |(onehot[g] & factors);
        end
    endgenerate

    always_comb begin
        routed_set = '0;
        for (int i = 0; i < `N_ROUTE; i++) begin
            routed_set = routed_set | onehot[i];
        end
    end

    // ************************************************************
    // aggregated inputs, routed factors masked out of aggregates 11-47 only
    // ************************************************************
    assign raw_agg = map_sel_ff ? i_alt_agg : i_legacy_agg;

    generate
        for (g = 0; g < `N_AGG; g = g + 1) begin : g_agg
            if (g >= `FIRST_MASKED_AGG && g <= `LAST_MASKED_AGG) begin : g_m
                // aggregate keeps only contributors not routed away
                assign nxt_agg[g] = map_sel_ff
                    ? |(factors & i_agg_factor_map[g*`N_FACTOR +: `N_FACTOR] & ~routed_set)
                      | (raw_agg[g] & ~|(i_agg_factor_map[g*`N_FACTOR +: `N_FACTOR]))
                    : raw_agg[g];
            end else begin : g_u
                assign nxt_agg[g] = raw_agg[g];
            end
        end
    endgenerate

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            agg_ff <= '0;
        end else if (i_ce) begin
            agg_ff <= nxt_agg;
        end
    end

    // monitor view shares the masked aggregate
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            mon_ff <= '0;
        end else if (i_ce) begin
            mon_ff <= nxt_agg;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            routed_ff <= '0;
        end else if (i_ce) begin
            routed_ff <= nxt_routed;
        end
    end

    // ************************************************************
    // nmi pin: three-stage sync, masked until configured
    // ************************************************************
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            nmi_sync_ff <= 3'h7;
            nmi_level_ff <= 1'b0;
        end else if (i_ce) begin
            nmi_sync_ff <= {nmi_sync_ff[1:0], i_nonmaskable_pin_n};
            if (nmi_sync_ff[2] == nmi_sync_ff[1]) begin
                nmi_level_ff <= ~nmi_sync_ff[2];
            end
        end
    end

    // watchdog request bypasses the pin mask
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            nmi_ff <= 1'b0;
        end else if (i_ce) begin
            nmi_ff <= (nmi_level_ff & nmi_en_ff) | i_watchdog_nmi;
        end
    end

    assign bus.rdata = rdata_ff;
    assign bus.ack = ack_ff;
    assign bus.agg_irq = agg_ff;
    assign bus.monitor = mon_ff;
    assign bus.routed_irq = routed_ff;
    assign bus.alt_mode = map_sel_ff;
    assign bus.nmi = nmi_ff;
endmodule // irq_remap_device
`default_nettype wire

// >>> verilog/irq_remap_core.sv
// controlling core end: issues register accesses, sees interrupts
`default_nettype none
`include "irq_remap_defines.svh"
module irq_remap_core (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    irq_remap_if.core bus,
    input wire logic i_cmd_valid,
    input wire logic i_cmd_wr,
    input wire logic [`ADDR_W-1:0] i_cmd_addr,
    input wire logic [31:0] i_cmd_wdata,
    output logic o_cmd_ready,
    output logic o_rsp_valid,
    output logic [31:0] o_rsp_rdata,
    output logic [`N_AGG-1:0] o_agg_irq,
    output logic [`N_ROUTE-1:0] o_routed_irq,
    output logic o_nmi
);
    irq_remap_pkg::host_state_t state_ff;
    logic req_ff;
    logic wr_ff;
    logic [`ADDR_W-1:0] addr_ff;
    logic [31:0] wdata_ff;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= irq_remap_pkg::HOST_IDLE;
            req_ff <= 1'b0;
            wr_ff <= 1'b0;
            addr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            o_cmd_ready <= 1'b1;
            o_rsp_valid <= 1'b0;
            o_rsp_rdata <= 32'h0000_0000;
        end else if (i_ce) begin
            o_rsp_valid <= 1'b0;
            case (state_ff)
                irq_remap_pkg::HOST_IDLE: begin
                    if (i_cmd_valid) begin
                        req_ff <= 1'b1;
                        wr_ff <= i_cmd_wr;
                        addr_ff <= i_cmd_addr;
                        // reserved map bits forced to zero
                        wdata_ff <= (i_cmd_addr == `OFS_VECTOR_MAP_SELECT)
                            ? {31'h0000_0000, i_cmd_wdata[0]} : i_cmd_wdata;
                        o_cmd_ready <= 1'b0;
                        state_ff <= irq_remap_pkg::HOST_ISSUE;
                    end
                end
                irq_remap_pkg::HOST_ISSUE: begin
                    req_ff <= 1'b0;
                    state_ff <= irq_remap_pkg::HOST_WAIT;
                end
                irq_remap_pkg::HOST_WAIT: begin
                    if (bus.ack) begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_rdata <= bus.rdata;
                        o_cmd_ready <= 1'b1;
                        state_ff <= irq_remap_pkg::HOST_IDLE;
                    end
                end
                default: state_ff <= irq_remap_pkg::HOST_IDLE;
            endcase
        end
    end

    // level requests registered straight through
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_agg_irq <= '0;
            o_routed_irq <= '0;
            o_nmi <= 1'b0;
        end else if (i_ce) begin
            o_agg_irq <= bus.agg_irq;
            o_routed_irq <= bus.routed_irq;
            o_nmi <= bus.nmi;
        end
    end

    assign bus.req = req_ff;
    assign bus.wr = wr_ff;
    assign bus.addr = addr_ff;
    assign bus.wdata = wdata_ff;
endmodule // irq_remap_core
`default_nettype wire

// >>> test/irq_remap_asserts.sv
// assertions on the remap link signals
`default_nettype none
`include "irq_remap_defines.svh"
module irq_remap_asserts (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic req,
    input wire logic wr,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic ack,
    input wire logic [`N_AGG-1:0] agg_irq,
    input wire logic [`N_ROUTE-1:0] routed_irq,
    input wire logic [`N_AGG-1:0] monitor,
    input wire logic alt_mode,
    input wire logic nmi
);
    // ****************
    // link checks
    // ****************
    logic nmi_en_ff;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    sequence s_map_wr;
        req && wr && addr == 4'h0;
    endsequence
    sequence s_map_rd;
        req && !wr && addr == 4'h0;
    endsequence
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            nmi_en_ff <= 1'b0;
        end else if (req && wr && addr == 4'hc) begin
            nmi_en_ff <= wdata[0];
        end
    end
    a_ack_after_req: assert property (req |=> ack) else $error("no ack after request");
    a_ack_pairs: assert property (ack |-> $past(req)) else $error("ack without request");
    a_map_read_zero: assert property (s_map_rd |=> rdata == {31'h0, alt_mode})
        else $error("map select read wrong");
    a_map_write_takes: assert property (s_map_wr |=> alt_mode == $past(wdata[0]))
        else $error("map bit not written");
    a_map_hold: assert property (!(req && wr && addr == 4'h0) |=> $stable(alt_mode))
        else $error("map bit changed alone");
    a_legacy_no_route: assert property (!alt_mode |=> routed_irq == 8'h0)
        else $error("routing in legacy mode");
    a_mode_first_edge: assert property ($rose(alt_mode) |-> routed_irq == 8'h0)
        else $error("routing ahead of mode");
    a_monitor_same: assert property (monitor == agg_irq) else $error("monitor differs");
    a_nmi_masked: assert property (!nmi_en_ff |-> !nmi) else $error("nmi while masked");
endmodule // irq_remap_asserts
`default_nettype wire

// >>> test/irq_vector_factor_remap_bench.sv
// testbench joining device and core ends of the remap link
`default_nettype none
module irq_vector_factor_remap_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // bench
    // ****************
    logic i_mclk = 1'b0;
    logic i_nrst = 1'b0;
    logic v = 1'b0, w = 1'b0, pin_n = 1'b1, ce = 1'b1, wdog = 1'b0, rdy, rv, nmi;
    logic [3:0] a = 4'h0, ser = 4'h0, dma = 4'h0;
    logic [31:0] d = 32'h0, q;
    logic [11:0] ext = 12'h0;
    logic [7:0] bt0 = 8'h0, bt1 = 8'h0, rt;
    logic [2:0] mot = 3'h0;
    logic [47:0] leg = 48'h0, alt = 48'h0, agg;
    logic [1535:0] fmap = 1536'h0;
    int failures = 0;
    int n_checks = 0;
    irq_remap_if bus ();
    irq_remap_device u_irq_remap_device (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(ce),
        .bus(bus), .i_ext_irq(ext), .i_bt_irq0(bt0), .i_bt_irq1(bt1), .i_ser_rx_irq(ser),
        .i_mot_zero_irq(mot), .i_dma_irq(dma), .i_legacy_agg(leg), .i_alt_agg(alt),
        .i_agg_factor_map(fmap), .i_nonmaskable_pin_n(pin_n), .i_watchdog_nmi(wdog));
    irq_remap_core u_irq_remap_core (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(ce),
        .bus(bus), .i_cmd_valid(v), .i_cmd_wr(w), .i_cmd_addr(a), .i_cmd_wdata(d),
        .o_cmd_ready(rdy), .o_rsp_valid(rv), .o_rsp_rdata(q), .o_agg_irq(agg),
        .o_routed_irq(rt), .o_nmi(nmi));
    irq_remap_asserts u_irq_remap_asserts (.i_mclk(i_mclk), .i_nrst(i_nrst),
        .req(bus.req), .wr(bus.wr), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
        .ack(bus.ack), .agg_irq(bus.agg_irq), .routed_irq(bus.routed_irq),
        .monitor(bus.monitor), .alt_mode(bus.alt_mode), .nmi(bus.nmi));
    always #12.5 i_mclk = ~i_mclk;
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask
    task automatic cmd(input logic wi, input logic [3:0] ai, input logic [31:0] di);
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 50) begin
            cyc(1);
            n++;
        end
        v = 1'b1;
        w = wi;
        a = ai;
        d = di;
        cyc(1);
        v = 1'b0;
        n = 0;
        while (rv !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        if (n == 20) failures++;
    endtask
    task automatic rd(input logic [3:0] ai, input logic [31:0] exp);
        cmd(1'b0, ai, 32'h0);
        chk({16'h0, q}, {16'h0, exp});
    endtask
    task automatic drive(input logic [7:0] c, input logic on);
        ext = 12'h0;
        bt0 = 8'h0;
        bt1 = 8'h0;
        ser = 4'h0;
        mot = 3'h0;
        dma = 4'h0;
        if (on && c >= 8'h01 && c <= 8'h0c) ext[c - 8'h01] = 1'b1;
        if (on && c >= 8'h0d && c <= 8'h14 && c[0]) bt1[c - 8'h0d] = 1'b1;
        if (on && c >= 8'h0d && c <= 8'h14 && !c[0]) bt0[c - 8'h0d] = 1'b1;
        if (on && c >= 8'h15 && c <= 8'h18) ser[c - 8'h15] = 1'b1;
        if (on && c >= 8'h19 && c <= 8'h1b) mot[c - 8'h19] = 1'b1;
        if (on && c >= 8'h1c && c <= 8'h1f) dma[c - 8'h1c] = 1'b1;
    endtask
    task automatic t_regs();
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
        cmd(1'b1, 4'h0, 32'hffff_ffff);
        rd(4'h0, 32'h1);
        cmd(1'b1, 4'h0, 32'h0);
        cmd(1'b1, 4'h4, 32'h0403_0201);
        cmd(1'b1, 4'h8, 32'h0807_0605);
        cmd(1'b1, 4'h2, 32'hffff_ffff);
        rd(4'h4, 32'h0403_0201);
        rd(4'h8, 32'h0807_0605);
        rd(4'h2, 32'h0);
        leg = 48'h1234_5678_9abc;
        drive(8'h01, 1'b1);
        cyc(3);
        chk({40'h0, rt}, 48'h0);
        chk(agg, leg);
    endtask
    task automatic t_codes();
        logic [7:0] c;
        int k;
        cmd(1'b1, 4'h0, 32'h1);
        // reserved codes 0x20 and up are never written
        for (int i = 0; i < 32; i++) begin
            c = i[7:0];
            k = i % 8;
            cmd(1'b1, 4'h4, k < 4 ? {24'h0, c} << (8 * k) : 32'h0);
            cmd(1'b1, 4'h8, k >= 4 ? {24'h0, c} << (8 * (k - 4)) : 32'h0);
            drive(c, 1'b1);
            cyc(3);
            chk({40'h0, rt}, (c >= 8'h01 && c <= 8'h1f) ? 48'h1 << k : 48'h0);
            drive(c, 1'b0);
            cyc(3);
            chk({40'h0, rt}, 48'h0);
        end
    endtask
    task automatic t_mask();
        fmap[10 * 32 + 1] = 1'b1;
        fmap[11 * 32 + 1] = 1'b1;
        fmap[47 * 32 + 1] = 1'b1;
        alt = 48'h8000_0000_0c00;
        cmd(1'b1, 4'h8, 32'h0);
        cmd(1'b1, 4'h4, 32'h0000_0001);
        drive(8'h01, 1'b1);
        cyc(3);
        chk(agg, 48'h0000_0000_0400);
        cmd(1'b1, 4'h4, 32'h0);
        cyc(3);
        chk(agg, alt);
        cmd(1'b1, 4'h0, 32'h0);
        cyc(3);
        chk(agg, leg);
    endtask
    task automatic t_freeze();
        logic [47:0] held;
        held = leg;
        ce = 1'b0;
        leg = ~held;
        cyc(4);
        chk(agg, held);
        ce = 1'b1;
        cyc(3);
        chk(agg, ~held);
    endtask
    task automatic t_nmi();
        pin_n = 1'b0;
        cyc(10);
        chk({47'h0, nmi}, 48'h0);
        cmd(1'b1, 4'hc, 32'h1);
        cyc(10);
        chk({47'h0, nmi}, 48'h1);
        pin_n = 1'b1;
        cyc(10);
        chk({47'h0, nmi}, 48'h0);
        wdog = 1'b1;
        cyc(3);
        chk({47'h0, nmi}, 48'h1);
        wdog = 1'b0;
        cyc(3);
        chk({47'h0, nmi}, 48'h0);
    endtask
    initial begin
        #100us;
        failures++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge i_mclk);
        #2;
        i_nrst = 1'b1;
        t_regs();
        t_codes();
        t_mask();
        t_freeze();
        t_nmi();
        conclude();
    end
endmodule // irq_vector_factor_remap_bench
`default_nettype wire
